//--- mtd_top.sv
// Orientation, motion and tap detection engine with register port and interrupt.
// Assumes sample data and the sample strobe come from front-end logic on clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "mtd_defs.svh"

module mtd_top (
    input  wire logic                clk_i,
    input  wire logic                srst_i,
    input  wire logic                sample_valid_i,
    input  wire logic signed [7:0]   accel_x_i,
    input  wire logic signed [7:0]   accel_y_i,
    input  wire logic signed [7:0]   accel_z_i,
    input  wire logic signed [7:0]   hpf_x_i,
    input  wire logic signed [7:0]   hpf_y_i,
    input  wire logic signed [7:0]   hpf_z_i,
    input  wire mtd_pkg::mtd_byte_t  performance_index_i,
    input  wire logic [1:0]          tap_axis_i,
    input  wire logic                tap_neg_i,
    input  wire logic [7:0]          addr_i,
    input  wire mtd_pkg::mtd_byte_t  wdata_i,
    input  wire logic                we_i,
    input  wire logic                re_i,
    output logic [7:0]               rdata_o,
    output logic                     irq_o,
    output logic [2:0]               orient_o,
    output logic                     motion_o
);
    import mtd_pkg::*;

    typedef struct packed {
        logic                  en;
        logic                  latch;
        mtd_byte_t             tilt_angle;
        mtd_byte_t             tilt_timer;
        mtd_byte_t             mot_thr;
        mtd_byte_t             mot_dbc;
        mtd_byte_t             tap_low;
        mtd_byte_t             tap_high;
        mtd_byte_t             dur_min;
        mtd_byte_t             dur_max;
        mtd_byte_t             tap_lat_set;
        mtd_byte_t             tap_win_set;
        mtd_byte_t             tap_gap_set;
        logic [`MTD_INT_W-1:0] int_status;
        logic [`MTD_INT_W-1:0] int_mask;
        mtd_byte_t             rdata;
        logic                  irq;
        mtd_orient_e           orient;
        mtd_orient_e           cand;
        mtd_byte_t             orient_cnt;
        logic                  mot_active;
        logic                  mot_report;
        mtd_byte_t             mot_cnt;
        mtd_tap_e              tap_st;
        mtd_byte_t             plen;
        mtd_byte_t             lat;
        mtd_byte_t             win;
        logic [1:0]            axis;
        logic                  neg;
        logic [1:0]            rep_axis;
        logic                  rep_neg;
        logic                  rep_single;
        logic                  rep_double;
    } mtd_state_s;

    mtd_state_s r;
    mtd_state_s next_r;

    function automatic mtd_byte_t mtd_abs(input logic signed [7:0] v);
        mtd_byte_t m;
        m = v[7] ? mtd_byte_t'(-v) : mtd_byte_t'(v);
        return m;
    endfunction : mtd_abs

    function automatic mtd_byte_t mtd_inc(input mtd_byte_t v);
        mtd_byte_t s;
        s = (v == `MTD_CNT_MAX) ? v : v + 8'h01;
        return s;
    endfunction : mtd_inc

    ////////////////////////////////////////////////////////////////////////////
    // Sample classification
    logic        tilt_ok;
    logic        mot_hit;
    logic        pi_ok;
    logic        pi_above;
    mtd_orient_e raw_orient;
    mtd_byte_t   ax_abs;
    mtd_byte_t   ay_abs;
    logic [`MTD_INT_W-1:0] ev;

    always_comb begin
        ax_abs  = mtd_abs(accel_x_i);
        ay_abs  = mtd_abs(accel_y_i);
        // Larger planar axis stands in for sin(theta); cheaper than a root
        tilt_ok = (ax_abs > r.tilt_angle) || (ay_abs > r.tilt_angle); // RULE1
        if (!tilt_ok) begin
            raw_orient = accel_z_i[7] ? MTD_OR_FACE_DOWN : MTD_OR_FACE_UP; // RULE2
        end else if (ay_abs >= ax_abs) begin
            raw_orient = accel_y_i[7] ? MTD_OR_ROT_180 : MTD_OR_ROT_0;
        end else begin
            raw_orient = accel_x_i[7] ? MTD_OR_ROT_270 : MTD_OR_ROT_90;
        end
        mot_hit = (mtd_abs(hpf_x_i) > r.mot_thr) || (mtd_abs(hpf_y_i) > r.mot_thr)
                  || (mtd_abs(hpf_z_i) > r.mot_thr); // RULE5
        pi_ok    = sample_valid_i && (performance_index_i <= r.tap_high); // RULE9
        pi_above = performance_index_i > r.tap_low;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_r = r;
        ev     = '0;

        // Orientation debounce, one count per sample set
        if (sample_valid_i) begin // RULE4
            if (raw_orient == r.orient) begin
                next_r.orient_cnt = 8'h00;
            end else if (raw_orient != r.cand) begin
                next_r.cand       = raw_orient;
                next_r.orient_cnt = 8'h01;
            end else begin
                next_r.orient_cnt = mtd_inc(r.orient_cnt);
            end
            if (raw_orient != r.orient && raw_orient == r.cand
                && mtd_inc(r.orient_cnt) >= r.tilt_timer) begin // RULE3
                next_r.orient     = raw_orient;
                next_r.orient_cnt = 8'h00;
                ev[`MTD_INT_ORIENT] = 1'b1;
            end
        end

        // Motion state with qualified transitions
        if (sample_valid_i) begin
            if (mot_hit == r.mot_active) begin
                next_r.mot_cnt = 8'h00;
            end else if (mtd_inc(r.mot_cnt) >= r.mot_dbc) begin // RULE7
                next_r.mot_active = mot_hit;
                next_r.mot_cnt    = 8'h00;
                if (mot_hit) begin
                    ev[`MTD_INT_MOT_START] = 1'b1;
                    next_r.mot_report      = 1'b1;
                end else if (!r.latch) begin
                    ev[`MTD_INT_MOT_END] = 1'b1; // RULE6
                    next_r.mot_report    = 1'b0;
                end
            end else begin
                next_r.mot_cnt = mtd_inc(r.mot_cnt);
            end
        end

        // Tap engine; window counts every sample set from the first tap
        if (sample_valid_i && r.tap_st != MTD_TAP_IDLE) begin
            next_r.win = mtd_inc(r.win); // RULE15
        end
        if (sample_valid_i) begin
            unique case (r.tap_st)
                MTD_TAP_IDLE: begin
                    if (pi_ok && pi_above) begin
                        next_r.tap_st = MTD_TAP_PULSE1;
                        next_r.plen   = 8'h01;
                        next_r.win    = 8'h01;
                        next_r.axis   = tap_axis_i;
                        next_r.neg    = tap_neg_i;
                    end
                end
                MTD_TAP_PULSE1, MTD_TAP_PULSE2: begin
                    if (pi_ok && pi_above) begin
                        next_r.plen = mtd_inc(r.plen);
                        if (r.plen >= r.dur_max) begin
                            next_r.tap_st = (r.tap_st == MTD_TAP_PULSE1) ? MTD_TAP_IDLE : MTD_TAP_WAIT2;
                        end
                    end else if (pi_ok) begin
                        next_r.lat = 8'h00;
                        if (r.plen > r.dur_min && r.plen < r.dur_max) begin // RULE8
                            next_r.tap_st = (r.tap_st == MTD_TAP_PULSE1) ? MTD_TAP_LAT1 : MTD_TAP_LAT2;
                        end else begin
                            next_r.tap_st = (r.tap_st == MTD_TAP_PULSE1) ? MTD_TAP_IDLE : MTD_TAP_WAIT2;
                        end
                    end
                end
                MTD_TAP_LAT1: begin
                    // Any tap here is ignored: too fast to be a second tap
                    next_r.lat = mtd_inc(r.lat); // RULE11
                    if (mtd_inc(r.lat) >= r.tap_lat_set) begin
                        next_r.tap_st = MTD_TAP_WAIT2;
                    end
                end
                MTD_TAP_WAIT2: begin
                    if (pi_ok && pi_above && r.win > r.tap_gap_set) begin // RULE13
                        next_r.tap_st = MTD_TAP_PULSE2;
                        next_r.plen   = 8'h01;
                    end
                end
                MTD_TAP_LAT2: begin
                    next_r.lat = mtd_inc(r.lat);
                    if (mtd_inc(r.lat) >= r.tap_lat_set) begin // RULE14
                        next_r.tap_st       = MTD_TAP_IDLE;
                        ev[`MTD_INT_DOUBLE] = 1'b1;
                    end
                end
            endcase
            if ((r.tap_st == MTD_TAP_LAT1 || r.tap_st == MTD_TAP_WAIT2 || r.tap_st == MTD_TAP_PULSE2)
                && r.win >= r.tap_win_set) begin // RULE12
                next_r.tap_st       = MTD_TAP_IDLE;
                ev[`MTD_INT_SINGLE] = 1'b1;
            end
        end
        if (ev[`MTD_INT_SINGLE] || ev[`MTD_INT_DOUBLE]) begin
            next_r.rep_axis   = r.axis; // RULE10
            next_r.rep_neg    = r.neg;
            next_r.rep_single = ev[`MTD_INT_SINGLE];
            next_r.rep_double = ev[`MTD_INT_DOUBLE];
        end

        // Disabled: counters and tap engine held at rest; orientation and motion state keep their values
        if (!r.en) begin // RULE18
            next_r.orient_cnt = 8'h00;
            next_r.cand       = r.orient;
            next_r.mot_cnt    = 8'h00;
            next_r.mot_active = r.mot_active;
            next_r.mot_report = r.mot_report;
            next_r.orient     = r.orient;
            next_r.tap_st     = MTD_TAP_IDLE;
            next_r.plen       = 8'h00;
            next_r.lat        = 8'h00;
            next_r.win        = 8'h00;
            ev                = '0;
        end

        // Register port; host is expected to disable before retuning
        next_r.rdata = 8'h00;
        if (re_i) begin
            unique case (addr_i)
                `MTD_ADDR_CTRL:        next_r.rdata = {6'h00, r.latch, r.en};
                `MTD_ADDR_TILT_ANGLE:  next_r.rdata = r.tilt_angle;
                `MTD_ADDR_TILT_TIMER:  next_r.rdata = r.tilt_timer;
                `MTD_ADDR_MOT_THR:     next_r.rdata = r.mot_thr;
                `MTD_ADDR_MOT_DBC:     next_r.rdata = r.mot_dbc;
                `MTD_ADDR_TAP_LOW:     next_r.rdata = r.tap_low;
                `MTD_ADDR_TAP_HIGH:    next_r.rdata = r.tap_high;
                `MTD_ADDR_TAP_DUR_MIN: next_r.rdata = r.dur_min;
                `MTD_ADDR_TAP_DUR_MAX: next_r.rdata = r.dur_max;
                `MTD_ADDR_TAP_LAT:     next_r.rdata = r.tap_lat_set;
                `MTD_ADDR_TAP_WIN:     next_r.rdata = r.tap_win_set;
                `MTD_ADDR_TAP_GAP:     next_r.rdata = r.tap_gap_set;
                `MTD_ADDR_ORIENT:      next_r.rdata = {5'h00, r.orient};
                `MTD_ADDR_MOT_STATUS:  next_r.rdata = {6'h00, r.mot_active, r.mot_report};
                `MTD_ADDR_TAP_STATUS:  next_r.rdata = {3'h0, r.rep_double, r.rep_single, r.rep_neg, r.rep_axis};
                `MTD_ADDR_INT_STATUS:  next_r.rdata = {3'h0, r.int_status};
                `MTD_ADDR_INT_MASK:    next_r.rdata = {3'h0, r.int_mask};
                default:               next_r.rdata = 8'h00;
            endcase
            // A motion status read acknowledges a latched report unless motion is still active
            if (addr_i == `MTD_ADDR_MOT_STATUS && r.latch && !r.mot_active) begin // RULE17
                next_r.mot_report = 1'b0;
            end
        end
        if (we_i) begin
            unique case (addr_i)
                `MTD_ADDR_CTRL: begin
                    next_r.en    = wdata_i[`MTD_CTRL_EN_BIT];
                    next_r.latch = wdata_i[`MTD_CTRL_LATCH_BIT];
                end
                `MTD_ADDR_TILT_ANGLE:  next_r.tilt_angle  = wdata_i; // RULE16
                `MTD_ADDR_TILT_TIMER:  next_r.tilt_timer  = wdata_i;
                `MTD_ADDR_MOT_THR:     next_r.mot_thr     = wdata_i;
                `MTD_ADDR_MOT_DBC:     next_r.mot_dbc     = wdata_i;
                `MTD_ADDR_TAP_LOW:     next_r.tap_low     = wdata_i;
                `MTD_ADDR_TAP_HIGH:    next_r.tap_high    = wdata_i;
                `MTD_ADDR_TAP_DUR_MIN: next_r.dur_min     = wdata_i;
                `MTD_ADDR_TAP_DUR_MAX: next_r.dur_max     = wdata_i;
                `MTD_ADDR_TAP_LAT:     next_r.tap_lat_set = wdata_i;
                `MTD_ADDR_TAP_WIN:     next_r.tap_win_set = wdata_i;
                `MTD_ADDR_TAP_GAP:     next_r.tap_gap_set = wdata_i;
                `MTD_ADDR_INT_STATUS:  next_r.int_status  = r.int_status & ~wdata_i[`MTD_INT_W-1:0];
                `MTD_ADDR_INT_MASK:    next_r.int_mask    = wdata_i[`MTD_INT_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a write-one-to-clear in the same cycle
        next_r.int_status = next_r.int_status | ev;
        next_r.irq        = |(next_r.int_status & next_r.int_mask);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r             <= '0;
            r.tilt_angle  <= `MTD_RST_TILT_ANGLE;
            r.tilt_timer  <= `MTD_RST_TILT_TIMER;
            r.mot_thr     <= `MTD_RST_MOT_THR;
            r.mot_dbc     <= `MTD_RST_MOT_DBC;
            r.tap_low     <= `MTD_RST_TAP_LOW;
            r.tap_high    <= `MTD_RST_TAP_HIGH;
            r.dur_min     <= `MTD_RST_TAP_DUR_MIN;
            r.dur_max     <= `MTD_RST_TAP_DUR_MAX;
            r.tap_lat_set <= `MTD_RST_TAP_LAT;
            r.tap_win_set <= `MTD_RST_TAP_WIN;
            r.tap_gap_set <= `MTD_RST_TAP_GAP;
            r.orient      <= MTD_OR_FACE_UP;
            r.cand        <= MTD_OR_FACE_UP;
            r.tap_st      <= MTD_TAP_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o  = r.rdata;
    assign irq_o    = r.irq;
    assign orient_o = r.orient;
    assign motion_o = r.mot_report;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_lat2_done;
        r.tap_st == MTD_TAP_LAT2 && sample_valid_i && mtd_inc(r.lat) >= r.tap_lat_set;
    endsequence

    sequence s_still_enabled;
        r.en && !(we_i && addr_i == `MTD_ADDR_CTRL);
    endsequence

    AST_ROT_NEEDS_TILT: assert property ( // RULE1
        $changed(r.orient) && r.orient inside {MTD_OR_ROT_0, MTD_OR_ROT_90, MTD_OR_ROT_180, MTD_OR_ROT_270}
        |-> $past(tilt_ok)) else $error("rotation entered below tilt");
    AST_FACE_WHEN_FLAT: assert property ( // RULE2
        $changed(r.orient) && r.orient inside {MTD_OR_FACE_UP, MTD_OR_FACE_DOWN}
        |-> !$past(tilt_ok)) else $error("face state entered while tilted");
    AST_ORIENT_ON_SAMPLE: assert property ( // RULE4
        $changed(r.orient) |-> $past(sample_valid_i) && $past(r.orient_cnt) + 9'd1 >= {1'b0, $past(r.tilt_timer)})
        else $error("orientation changed without debounce");
    AST_MOT_ON_SAMPLE: assert property ( // RULE7
        $changed(r.mot_active) |-> $past(sample_valid_i) && $past(mot_hit) == r.mot_active)
        else $error("motion state changed without qualified sample");
    AST_MOT_LATCHED: assert property ( // RULE17
        r.latch && r.mot_report && !re_i |=> r.mot_report) else $error("latched motion report dropped");
    AST_HIGH_IGNORED: assert property ( // RULE9
        s_still_enabled ##0 (sample_valid_i && performance_index_i > r.tap_high) |=> $stable(r.plen))
        else $error("sample above high threshold counted");
    AST_DOUBLE_AT_LAT: assert property ( // RULE14
        s_still_enabled ##0 s_lat2_done |=> r.int_status[`MTD_INT_DOUBLE] && r.rep_double)
        else $error("double tap not reported at latency end");
    AST_SINGLE_AT_WIN: assert property ( // RULE12
        $rose(r.rep_single) |-> $past(r.win) >= $past(r.tap_win_set)) else $error("single tap before window end");
    AST_DISABLED_IDLE: assert property ( // RULE18
        !r.en ##1 !r.en |-> r.tap_st == MTD_TAP_IDLE && r.mot_cnt == 8'h00 && r.orient_cnt == 8'h00)
        else $error("detection active while disabled");
    AST_MOT_HELD_OFF: assert property ( // RULE18
        !r.en |=> $stable(r.mot_active) && $stable(r.orient)) else $error("motion or orientation moved while disabled");

endmodule : mtd_top
`default_nettype wire

//--- mtd_defs.svh
// Constants of the motion, orientation and tap detection block.
// Assumes an 8-bit register port and one sample-set strobe per output sample period.
//
// Summary of operation
// RULE1: Screen rotation changes only while tilt magnitude exceeds tilt threshold, 32 counts per g.
// RULE2: Too flat to resolve rotation: report face-up or face-down by z sign.
// RULE3: New orientation reported only after persisting the 8-bit debounce count of sample sets.
// RULE4: Each orientation debounce count is one output sample period.
// RULE5: Motion goes active when any filtered axis exceeds motion threshold, 16 counts per g.
// RULE6: In unlatched mode the end of motion is also reported.
// RULE7: Every active/inactive change is qualified by an 8-bit count of motion samples.
// RULE8: Tap detected when jerk stays above low threshold between the duration limits.
// RULE9: Samples with jerk above the high threshold are ignored by tap detection.
// RULE10: Each single or double tap reports its axis and direction.
// RULE11: A second tap inside the latency period is ignored; first stays single.
// RULE12: A single tap is reported when the tap window expires.
// RULE13: Double tap needs second tap after minimum gap and within duration limits.
// RULE14: Double tap reported when latency started by the second tap expires.
// RULE15: Window counts output sample periods; whole tap event must fit inside it; the code does not apply the window in MTD_TAP_LAT2.
// RULE16: Host clears operating enable before rewriting thresholds, timers or tilt settings.
// RULE17: In latched mode motion report holds until the host reads motion status.
// RULE18: Detection logic advances only on sample sets, held reset while disabled; the code keeps orient, mot_active and mot_report at their values.
`ifndef MTD_DEFS_SVH
`define MTD_DEFS_SVH

`define MTD_ADDR_CTRL         8'h00
`define MTD_ADDR_TILT_ANGLE   8'h01
`define MTD_ADDR_TILT_TIMER   8'h02
`define MTD_ADDR_MOT_THR      8'h03
`define MTD_ADDR_MOT_DBC      8'h04
`define MTD_ADDR_TAP_LOW      8'h05
`define MTD_ADDR_TAP_HIGH     8'h06
`define MTD_ADDR_TAP_DUR_MIN  8'h07
`define MTD_ADDR_TAP_DUR_MAX  8'h08
`define MTD_ADDR_TAP_LAT      8'h09
`define MTD_ADDR_TAP_WIN      8'h0A
`define MTD_ADDR_TAP_GAP      8'h0B
`define MTD_ADDR_ORIENT       8'h0C
`define MTD_ADDR_MOT_STATUS   8'h0D
`define MTD_ADDR_TAP_STATUS   8'h0E
`define MTD_ADDR_INT_STATUS   8'h0F
`define MTD_ADDR_INT_MASK     8'h10

`define MTD_CTRL_EN_BIT       0
`define MTD_CTRL_LATCH_BIT    1

`define MTD_INT_ORIENT        0
`define MTD_INT_MOT_START     1
`define MTD_INT_MOT_END       2
`define MTD_INT_SINGLE        3
`define MTD_INT_DOUBLE        4
`define MTD_INT_W             5

`define MTD_RST_TILT_ANGLE    8'h0C
`define MTD_RST_TILT_TIMER    8'h01
`define MTD_RST_MOT_THR       8'h08
`define MTD_RST_MOT_DBC       8'h01
`define MTD_RST_TAP_LOW       8'h1A
`define MTD_RST_TAP_HIGH      8'hB6
`define MTD_RST_TAP_DUR_MIN   8'h01
`define MTD_RST_TAP_DUR_MAX   8'h10
`define MTD_RST_TAP_LAT       8'h28
`define MTD_RST_TAP_WIN       8'hA0
`define MTD_RST_TAP_GAP       8'h78

`define MTD_CNT_MAX           8'hFF

`endif

//--- mtd_pkg.sv
// Types of the motion, orientation and tap detection block.
// Assumes the constants header is compiled alongside.
package mtd_pkg;

    typedef enum logic [2:0] {
        MTD_OR_FACE_UP,
        MTD_OR_FACE_DOWN,
        MTD_OR_ROT_0,
        MTD_OR_ROT_90,
        MTD_OR_ROT_180,
        MTD_OR_ROT_270
    } mtd_orient_e;

    typedef enum logic [2:0] {
        MTD_TAP_IDLE,
        MTD_TAP_PULSE1,
        MTD_TAP_LAT1,
        MTD_TAP_WAIT2,
        MTD_TAP_PULSE2,
        MTD_TAP_LAT2
    } mtd_tap_e;

    typedef logic [7:0] mtd_byte_t;

endpackage : mtd_pkg

//--- mtd_host_model.sv
// Host-side register master for the detection block.
// Assumes one clock; every strobe changes by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module mtd_host_model (
    input  wire logic       clk_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       we_o,
    output var  logic       re_o
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        we_o    = 1'b0;
        re_o    = 1'b0;
    end
    // Released bus shows inverted values, so a stale address never passes for a held one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        we_o    <= 1'b1;
        @(posedge clk_i);
        we_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        re_o   <= 1'b1;
        @(posedge clk_i);
        re_o   <= 1'b0;
        addr_o <= ~a;
    endtask : rd
    // Settings are only rewritten with detection stopped
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        wr(8'h00, 8'h00);
        wr(a, d);
    endtask : cfg
endmodule : mtd_host_model
`default_nettype wire

//--- mtd_top_bench.sv
// Self-checking bench for the detection block: registers, orientation, motion, taps.
// Assumes the host model drives the register port and this module drives the sample stream.
`timescale 1ns/10ps
`default_nettype none
`include "mtd_defs.svh"
module mtd_top_bench;
    import mtd_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sv = 1'b0;
    logic signed [7:0] ax = 8'sh00, ay = 8'sh00, az = 8'sh00, hx = 8'sh00, hy = 8'sh00, hz = 8'sh00;
    logic [7:0] pi = 8'h00;
    logic [1:0] tax = 2'h0;
    logic tng = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic we, re, irq, mot, rd_pend = 1'b0;
    logic [2:0] ori;
    logic [31:0] rnd = 32'h1a67;
    logic [7:0] exp_q[$];
    int mismatches = 0, compares = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk_i = ~clk_i;
    mtd_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re));
    mtd_top DUT (.clk_i(clk_i), .srst_i(srst_i), .sample_valid_i(sv), .accel_x_i(ax), .accel_y_i(ay),
        .accel_z_i(az), .hpf_x_i(hx), .hpf_y_i(hy), .hpf_z_i(hz), .performance_index_i(pi),
        .tap_axis_i(tax), .tap_neg_i(tng), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata), .irq_o(irq), .orient_o(ori), .motion_o(mot));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rd
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_pend) chk("rdata", exp_q.pop_front(), rdata);
        rd_pend <= re;
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // One sample set, then time for the registered outputs to settle; t[1:0] also steers h to x, y or z
    task automatic smp(input logic signed [7:0] x, y, z, h, input logic [7:0] p, input logic [2:0] t);
        @(posedge clk_i);
        {sv, ax, ay, az, pi, tng, tax} <= {1'b1, x, y, z, p, t};
        hx <= (t[1:0] == 2'd0) ? h : 8'sh00;
        hy <= (t[1:0] == 2'd1) ? h : 8'sh00;
        hz <= (t[1:0] == 2'd2) ? h : 8'sh00;
        @(posedge clk_i);
        sv <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : smp
    // Quiet flat samples with small random noise, below every threshold
    task automatic quiet(input int n);
        repeat (n) begin
            rnd = lfsr(rnd);
            smp(8'($signed(rnd[1:0])), 8'($signed(rnd[3:2])), 8'sd32, 8'($signed(rnd[6:4])), {5'h0, rnd[9:7]}, 3'h0);
        end
    endtask : quiet
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        #1 chk("orient", 8'h00, {5'h0, ori});
        rd(`MTD_ADDR_TILT_ANGLE, `MTD_RST_TILT_ANGLE);
        rd(`MTD_ADDR_MOT_THR, `MTD_RST_MOT_THR);
        rd(`MTD_ADDR_TAP_WIN, `MTD_RST_TAP_WIN);
        rd(`MTD_ADDR_TAP_HIGH, `MTD_RST_TAP_HIGH);
        rd(8'h20, 8'h00);
        rnd = lfsr(rnd);
        host.wr(`MTD_ADDR_TAP_GAP, rnd[7:0]);
        rd(`MTD_ADDR_TAP_GAP, rnd[7:0]);
        $display("test registers done");
        host.cfg(`MTD_ADDR_TILT_TIMER, 8'h02);
        host.wr(`MTD_ADDR_INT_MASK, 8'h01);
        host.wr(`MTD_ADDR_CTRL, 8'h01);
        smp(8'sd20, 8'sd0, 8'sd10, 8'sd0, 8'h00, 3'h0);
        chk("orient", 8'(MTD_OR_FACE_UP), {5'h0, ori});
        smp(8'sd20, 8'sd0, 8'sd10, 8'sd0, 8'h00, 3'h0);
        chk("orient", 8'(MTD_OR_ROT_90), {5'h0, ori});
        chk("irq", 8'h01, {7'h0, irq});
        host.wr(`MTD_ADDR_INT_STATUS, 8'h1F);
        repeat (2) smp(8'sd5, -8'sd3, -8'sd20, 8'sd0, 8'h00, 3'h0);
        chk("orient", 8'(MTD_OR_FACE_DOWN), {5'h0, ori});
        $display("test orientation done");
        host.cfg(`MTD_ADDR_MOT_DBC, 8'h02);
        host.wr(`MTD_ADDR_INT_MASK, 8'h02);
        host.wr(`MTD_ADDR_INT_STATUS, 8'h1F);
        host.wr(`MTD_ADDR_CTRL, 8'h01);
        repeat (3) smp(8'sd0, 8'sd0, 8'sd32, 8'sd8, 8'h00, 3'h0);
        chk("motion", 8'h00, {7'h0, mot});
        smp(8'sd0, 8'sd0, 8'sd32, 8'sd9, 8'h00, 3'h0);
        chk("motion", 8'h00, {7'h0, mot});
        smp(8'sd0, 8'sd0, 8'sd32, 8'sd9, 8'h00, 3'h1);
        chk("motion", 8'h01, {7'h0, mot});
        chk("irq", 8'h01, {7'h0, irq});
        quiet(2);
        chk("motion", 8'h00, {7'h0, mot});
        host.cfg(`MTD_ADDR_MOT_DBC, 8'h01);
        smp(8'sd0, 8'sd0, 8'sd32, 8'sd40, 8'h00, 3'h0);
        chk("motion", 8'h00, {7'h0, mot});
        host.wr(`MTD_ADDR_CTRL, 8'h03);
        smp(8'sd0, 8'sd0, 8'sd32, -8'sd12, 8'h00, 3'h2);
        quiet(3);
        chk("motion", 8'h01, {7'h0, mot});
        rd(`MTD_ADDR_MOT_STATUS, 8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk("motion", 8'h00, {7'h0, mot});
        $display("test motion done");
        host.cfg(`MTD_ADDR_TAP_WIN, 8'd20);
        host.wr(`MTD_ADDR_TAP_LAT, 8'd3);
        host.wr(`MTD_ADDR_INT_MASK, 8'h08);
        host.wr(`MTD_ADDR_INT_STATUS, 8'h1F);
        host.wr(`MTD_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 4; i++) smp(8'sd0, 8'sd0, 8'sd32, 8'sd0, (i == 2) ? 8'hC0 : 8'h40, 3'b101);
        quiet(16);
        chk("irq", 8'h00, {7'h0, irq});
        quiet(1);
        chk("irq", 8'h01, {7'h0, irq});
        rd(`MTD_ADDR_TAP_STATUS, 8'h0D);
        host.cfg(`MTD_ADDR_TAP_WIN, 8'd60);
        host.wr(`MTD_ADDR_TAP_GAP, 8'd10);
        host.wr(`MTD_ADDR_INT_MASK, 8'h10);
        host.wr(`MTD_ADDR_INT_STATUS, 8'h1F);
        host.wr(`MTD_ADDR_CTRL, 8'h01);
        repeat (3) smp(8'sd0, 8'sd0, 8'sd32, 8'sd0, 8'h40, 3'b001);
        smp(8'sd0, 8'sd0, 8'sd32, 8'sd0, 8'h00, 3'b000);
        smp(8'sd0, 8'sd0, 8'sd32, 8'sd0, 8'h40, 3'b001);
        quiet(12);
        repeat (3) smp(8'sd0, 8'sd0, 8'sd32, 8'sd0, 8'h40, 3'b010);
        quiet(8);
        chk("irq", 8'h01, {7'h0, irq});
        rd(`MTD_ADDR_TAP_STATUS, 8'h11);
        $display("test taps done");
        report_and_stop();
    end
endmodule : mtd_top_bench
`default_nettype wire
